/* hdl/switch_link_config_regs.v */
// Purpose: Configuration and status registers of the message switch and its serial links
// Assumes: Avalon-MM slave, byte addresses, one clock; link and core inputs are on i_clk
// Notes: Every access is answered with one wait cycle; locked writes are accepted and dropped
//        Lock bit blocks every bus write, its own register included, until device reset; processor scratch writes still land
//        A read clears the link error flag only once that read has shown it
`timescale 1ns/1ps
`include "switch_link_config_defs.vh"

module switch_link_config_regs #(
    parameter NUM_LINKS = 8,
    parameter NUM_PLINKS = 4,
    parameter NUM_SCRATCH = 8,
    parameter [7:0] LINKS_ON_SWITCH = 8'h08,
    parameter [7:0] CORES_ON_SWITCH = 8'h01,
    parameter [7:0] LINKS_PER_PROC = 8'h04
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [9:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire [NUM_PLINKS-1:0] i_processor_link_route_into_switch,
    input wire [31:0] i_core0_program_counter,
    input wire i_ps_scratch_write,
    input wire [2:0] i_ps_scratch_index,
    input wire [31:0] i_ps_scratch_wdata,
    output reg [31:0] o_ps_scratch_rdata,
    input wire [NUM_LINKS-1:0] i_link_rx_overflow,
    input wire [NUM_LINKS-1:0] i_link_illegal_token,
    input wire [NUM_LINKS-1:0] i_link_credit_issued,
    input wire [NUM_LINKS-1:0] i_link_credit_held,
    output wire [NUM_LINKS-1:0] o_link_enable,
    output wire [NUM_LINKS-1:0] o_link_five_wire,
    output wire [NUM_LINKS-1:0] o_link_greeting_start,
    output wire [NUM_LINKS-1:0] o_link_rx_reset,
    output wire [NUM_LINKS*11-1:0] o_link_symbol_gap,
    output wire [NUM_LINKS*11-1:0] o_link_token_gap,
    output wire [NUM_LINKS-1:0] o_static_enable,
    output wire [NUM_LINKS*5-1:0] o_static_channel_end,
    output wire o_one_byte_headers,
    output wire o_write_locked,
    output wire [15:0] o_node_identifier,
    output wire [31:0] o_clock_multiplier_settings,
    output wire o_tile_reset
);

////////////////////////////////////////////////////////////////////////////////
// Bus handshake

reg ack_q;
wire req = i_avs_read | i_avs_write;
wire [7:0] idx = i_avs_address[9:2];
wire wr_acc = i_avs_write & ~i_avs_read & ack_q;
wire rd_acc = i_avs_read & ack_q;
reg lock_q;
wire wr_ok = wr_acc & ~lock_q;
wire [31:0] bmask;
wire [31:0] wd_m = i_avs_writedata & bmask;

// Lane masks; a single-bit field follows the lane that holds it
assign bmask[31:24] = {8{i_avs_byteenable[3]}};
assign bmask[23:16] = {8{i_avs_byteenable[2]}};
assign bmask[15:8] = {8{i_avs_byteenable[1]}};
assign bmask[7:0] = {8{i_avs_byteenable[0]}};

// One wait cycle per access keeps read data coming from a flip-flop
assign o_avs_waitrequest = ~ack_q;

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ack_q <= 1'b0;
    end else begin
        ack_q <= req & ~ack_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register decode

wire sel_desc = (idx == `IDX_SWITCH_DESCRIPTION);
wire sel_cfg = (idx == `IDX_SWITCH_CONFIGURATION);
wire sel_node = (idx == `IDX_NODE_IDENTIFIER);
wire sel_clk = (idx == `IDX_CLOCK_MULTIPLIER);
wire sel_processor_link = (idx[7:2] == `GRP4_PROCESSOR_LINK);
wire sel_scr = (idx[7:3] == `GRP8_SCRATCH);
wire sel_pc = (idx == `IDX_CORE0_PC);
wire sel_lcfg = (idx[7:3] == `GRP8_LINK_CONFIG);
wire sel_slnk = (idx[7:3] == `GRP8_STATIC_LINK);

////////////////////////////////////////////////////////////////////////////////
// Switch-wide registers

reg clklock_q;
reg hdr_q;
reg [15:0] node_id_q;
reg [31:0] clk_mult_q;
reg tile_rst_q;
reg [NUM_PLINKS-1:0] processor_link_q;

wire hit_cfg = wr_ok & sel_cfg;
wire hit_node = wr_ok & sel_node;
wire hit_clk = wr_ok & sel_clk & ~clklock_q;

// Lock is one-way: once set only a device reset clears it
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        lock_q <= 1'b0;
    end else if (hit_cfg && i_avs_byteenable[3]) begin
        lock_q <= i_avs_writedata[`SWCFG_LOCK_BIT];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        clklock_q <= 1'b0;
    end else if (hit_cfg && i_avs_byteenable[1]) begin
        clklock_q <= i_avs_writedata[`SWCFG_CLKLOCK_BIT];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        hdr_q <= 1'b0;
    end else if (hit_cfg && i_avs_byteenable[0]) begin
        hdr_q <= i_avs_writedata[`SWCFG_HDR_BIT];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        node_id_q <= `RST_NODE_ID;
    end else if (hit_node) begin
        node_id_q <= (node_id_q & ~bmask[15:0]) | wd_m[15:0];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        clk_mult_q <= `RST_WORD;
    end else if (hit_clk) begin
        clk_mult_q <= (clk_mult_q & ~bmask) | wd_m;
    end
end

// Tile reset leaves as a one-cycle pulse after an accepted clock multiplier write that neither lock bit drops
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        tile_rst_q <= 1'b0;
    end else begin
        tile_rst_q <= hit_clk;
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        processor_link_q <= {NUM_PLINKS{1'b0}};
    end else begin
        processor_link_q <= i_processor_link_route_into_switch;
    end
end

assign o_write_locked = lock_q;
assign o_one_byte_headers = hdr_q;
assign o_node_identifier = node_id_q;
assign o_clock_multiplier_settings = clk_mult_q;
assign o_tile_reset = tile_rst_q;

////////////////////////////////////////////////////////////////////////////////
// Debug scratch, shared with the processor status port

reg [31:0] scratch_q [0:NUM_SCRATCH-1];
wire hit_scr = wr_ok & sel_scr;
integer s;

// Bus write wins when both sides hit one word in one cycle
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        for (s = 0; s < NUM_SCRATCH; s = s + 1) begin
            scratch_q[s] <= `RST_WORD;
        end
    end else begin
        if (i_ps_scratch_write &&
            !(hit_scr && (idx[2:0] == i_ps_scratch_index))) begin
            scratch_q[i_ps_scratch_index] <= i_ps_scratch_wdata;
        end
        if (hit_scr) begin
            scratch_q[idx[2:0]] <= (scratch_q[idx[2:0]] & ~bmask) | wd_m;
        end
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_ps_scratch_rdata <= `RST_WORD;
    end else begin
        o_ps_scratch_rdata <= scratch_q[i_ps_scratch_index];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Link configuration and static forwarding, one slot per link

reg [NUM_LINKS-1:0] en_q;
reg [NUM_LINKS-1:0] five_q;
reg [NUM_LINKS-1:0] err_q;
reg [NUM_LINKS-1:0] greet_q;
reg [NUM_LINKS-1:0] rxrst_q;
reg [10:0] sym_gap_q [0:NUM_LINKS-1];
reg [10:0] tok_gap_q [0:NUM_LINKS-1];
reg [NUM_LINKS-1:0] st_en_q;
reg [4:0] chan_q [0:NUM_LINKS-1];

wire hit_lcfg = wr_ok & sel_lcfg;
wire hit_slnk = wr_ok & sel_slnk;
wire rd_lcfg = rd_acc & sel_lcfg;

genvar g;
generate
    for (g = 0; g < NUM_LINKS; g = g + 1) begin : g_link
        wire wsel = hit_lcfg & (idx[2:0] == g);
        // Slot order follows links C, D, A, B, G, H, E, F
        wire ssel = hit_slnk & (idx[2:0] == g);
        wire rsel = rd_lcfg & (idx[2:0] == g);
        wire ev = i_link_rx_overflow[g] | i_link_illegal_token[g];

        // New error in the clearing read's cycle is kept
        // Clearing only what the read showed keeps an error raised at the capture edge
        always @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                err_q[g] <= 1'b0;
            end else if (ev) begin
                err_q[g] <= 1'b1;
            end else if (rsel && o_avs_readdata[`LCFG_ERROR_BIT]) begin
                err_q[g] <= 1'b0;
            end
        end

        // Self-clearing bits leave as one-cycle pulses
        always @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                greet_q[g] <= 1'b0;
                rxrst_q[g] <= 1'b0;
            end else begin
                greet_q[g] <= wsel & i_avs_byteenable[3] &
                              i_avs_writedata[`LCFG_GREETING_BIT];
                rxrst_q[g] <= wsel & i_avs_byteenable[2] &
                              i_avs_writedata[`LCFG_RX_RESET_BIT];
            end
        end

        always @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                en_q[g] <= 1'b0;
                five_q[g] <= 1'b0;
                sym_gap_q[g] <= `RST_GAP;
                tok_gap_q[g] <= `RST_GAP;
            end else if (wsel) begin
                if (i_avs_byteenable[3]) begin
                    en_q[g] <= i_avs_writedata[`LCFG_ENABLE_BIT];
                    five_q[g] <= i_avs_writedata[`LCFG_FIVE_WIRE_BIT];
                end
                sym_gap_q[g] <= (sym_gap_q[g] &
                    ~bmask[`LCFG_SYM_GAP_MSB:`LCFG_SYM_GAP_LSB]) |
                    wd_m[`LCFG_SYM_GAP_MSB:`LCFG_SYM_GAP_LSB];
                tok_gap_q[g] <= (tok_gap_q[g] &
                    ~bmask[`LCFG_TOK_GAP_MSB:`LCFG_TOK_GAP_LSB]) |
                    wd_m[`LCFG_TOK_GAP_MSB:`LCFG_TOK_GAP_LSB];
            end
        end

        always @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                st_en_q[g] <= 1'b0;
                chan_q[g] <= `RST_CHAN;
            end else if (ssel) begin
                if (i_avs_byteenable[3]) begin
                    st_en_q[g] <= i_avs_writedata[`SLNK_ENABLE_BIT];
                end
                if (i_avs_byteenable[0]) begin
                    chan_q[g] <= i_avs_writedata[`SLNK_CHAN_MSB:`SLNK_CHAN_LSB];
                end
            end
        end

        assign o_link_symbol_gap[g*11 +: 11] = sym_gap_q[g];
        assign o_link_token_gap[g*11 +: 11] = tok_gap_q[g];
        assign o_static_channel_end[g*5 +: 5] = chan_q[g];
    end
endgenerate

assign o_link_enable = en_q;
assign o_link_five_wire = five_q;
assign o_link_greeting_start = greet_q;
assign o_link_rx_reset = rxrst_q;
assign o_static_enable = st_en_q;

////////////////////////////////////////////////////////////////////////////////
// Read data, captured in the wait cycle

reg [31:0] rd_d;
reg [2:0] li;

always @* begin
    rd_d = `RST_WORD;
    li = idx[2:0];
    if (sel_desc) begin
        rd_d[`SWDESC_LINKS_MSB:`SWDESC_LINKS_LSB] = LINKS_ON_SWITCH;
        rd_d[`SWDESC_CORES_MSB:`SWDESC_CORES_LSB] = CORES_ON_SWITCH;
        rd_d[`SWDESC_LPP_MSB:`SWDESC_LPP_LSB] = LINKS_PER_PROC;
    end else if (sel_cfg) begin
        rd_d[`SWCFG_LOCK_BIT] = lock_q;
        rd_d[`SWCFG_CLKLOCK_BIT] = clklock_q;
        rd_d[`SWCFG_HDR_BIT] = hdr_q;
    end else if (sel_node) begin
        rd_d[`NODE_ID_MSB:0] = node_id_q;
    end else if (sel_clk) begin
        rd_d = clk_mult_q;
    end else if (sel_processor_link) begin
        rd_d[0] = processor_link_q[idx[1:0]];
    end else if (sel_scr) begin
        rd_d = scratch_q[li];
    end else if (sel_pc) begin
        rd_d = i_core0_program_counter;
    end else if (sel_lcfg) begin
        rd_d[`LCFG_ENABLE_BIT] = en_q[li];
        rd_d[`LCFG_FIVE_WIRE_BIT] = five_q[li];
        rd_d[`LCFG_ERROR_BIT] = err_q[li];
        rd_d[`LCFG_CREDIT_ISSUED_BIT] = i_link_credit_issued[li];
        rd_d[`LCFG_CREDIT_HELD_BIT] = i_link_credit_held[li];
        rd_d[`LCFG_SYM_GAP_MSB:`LCFG_SYM_GAP_LSB] = sym_gap_q[li];
        rd_d[`LCFG_TOK_GAP_MSB:`LCFG_TOK_GAP_LSB] = tok_gap_q[li];
    end else if (sel_slnk) begin
        rd_d[`SLNK_ENABLE_BIT] = st_en_q[li];
        rd_d[`SLNK_CHAN_MSB:`SLNK_CHAN_LSB] = chan_q[li];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_avs_readdata <= `RST_WORD;
    end else if (i_avs_read && !ack_q) begin
        o_avs_readdata <= rd_d;
    end
end

endmodule // switch_link_config_regs

/* include/switch_link_config_defs.vh */
// Purpose: Register indices, field positions and reset values of the switch link registers
// Assumes: Included by switch_link_config_regs.v only
// Notes: Byte address of a register is four times its index
`ifndef SWITCH_LINK_CONFIG_DEFS_VH
`define SWITCH_LINK_CONFIG_DEFS_VH

// Register indices
`define IDX_SWITCH_DESCRIPTION 8'h01
`define IDX_SWITCH_CONFIGURATION 8'h04
`define IDX_NODE_IDENTIFIER 8'h05
`define IDX_CLOCK_MULTIPLIER 8'h06
`define IDX_PROCESSOR_LINK_STATUS_BASE 8'h10
`define IDX_DEBUG_SCRATCH_BASE 8'h20
`define IDX_CORE0_PC 8'h40
`define IDX_LINK_CONFIG_BASE 8'h80
`define IDX_STATIC_LINK_BASE 8'ha0

// Group decode: upper index bits of each register group
`define GRP8_SCRATCH 5'h04
`define GRP8_LINK_CONFIG 5'h10
`define GRP8_STATIC_LINK 5'h14
`define GRP4_PROCESSOR_LINK 6'h04

// Switch configuration fields
`define SWCFG_LOCK_BIT 31
`define SWCFG_CLKLOCK_BIT 8
`define SWCFG_HDR_BIT 0

// Switch description fields
`define SWDESC_LINKS_MSB 23
`define SWDESC_LINKS_LSB 16
`define SWDESC_CORES_MSB 15
`define SWDESC_CORES_LSB 8
`define SWDESC_LPP_MSB 7
`define SWDESC_LPP_LSB 0

// Link configuration fields
`define LCFG_ENABLE_BIT 31
`define LCFG_FIVE_WIRE_BIT 30
`define LCFG_ERROR_BIT 27
`define LCFG_CREDIT_ISSUED_BIT 26
`define LCFG_CREDIT_HELD_BIT 25
`define LCFG_GREETING_BIT 24
`define LCFG_RX_RESET_BIT 23
`define LCFG_SYM_GAP_MSB 21
`define LCFG_SYM_GAP_LSB 11
`define LCFG_TOK_GAP_MSB 10
`define LCFG_TOK_GAP_LSB 0

// Static link fields
`define SLNK_ENABLE_BIT 31
`define SLNK_CHAN_MSB 4
`define SLNK_CHAN_LSB 0

// Node identifier field
`define NODE_ID_MSB 15

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_GAP 11'h000
`define RST_CHAN 5'h00
`define RST_NODE_ID 16'h0000

`endif

/* testbench/remote_link_end.sv */
// Purpose: Remote switch end of every serial link
// Assumes: Same clock as the register block
// Notes: Reply delay picked at each greeting from i_slow; errors only when the bench commands them
`timescale 1ns/1ps
module remote_link_end #(parameter N = 8) (
    input logic i_clk,
    input logic i_rst_n,
    input logic i_slow,
    input logic [N-1:0] i_enable,
    input logic [N-1:0] i_greeting,
    input logic [N-1:0] i_bad_ovf,
    input logic [N-1:0] i_bad_tok,
    output logic [N-1:0] o_credit_issued,
    output logic [N-1:0] o_credit_held,
    output logic [N-1:0] o_overflow,
    output logic [N-1:0] o_illegal
);
    int cnt [N];
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_credit_issued <= '0;
            o_credit_held <= '0;
            o_overflow <= '0;
            o_illegal <= '0;
            foreach (cnt[n]) cnt[n] <= 0;
        end else begin
            o_credit_issued <= i_enable;
            o_overflow <= i_bad_ovf;
            o_illegal <= i_bad_tok;
            for (int n = 0; n < N; n++) begin
                // Greeting drops credit, reply comes late or soon
                if (i_greeting[n]) begin
                    o_credit_held[n] <= 1'b0;
                    cnt[n] <= i_slow ? 20 : 2;
                end else if (cnt[n] == 1) begin
                    o_credit_held[n] <= 1'b1;
                    cnt[n] <= 0;
                end else if (cnt[n] > 1) begin
                    cnt[n] <= cnt[n] - 1;
                end
            end
        end
    end
endmodule // remote_link_end

/* testbench/switch_link_config_regs_sva.sv */
// Purpose: Port-level checks of the switch link register block
// Assumes: Accept edge is where waitrequest is sampled low
// Notes: Clock multiplier lock bit is not visible, so tile reset is checked one way
`timescale 1ns/1ps
module switch_link_config_regs_sva #(parameter NUM_LINKS = 8) (
    input logic i_clk,
    input logic i_rst_n,
    input logic [9:0] i_avs_address,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic [3:0] i_avs_byteenable,
    input logic [31:0] o_avs_readdata,
    input logic o_avs_waitrequest,
    input logic [31:0] i_core0_program_counter,
    input logic [NUM_LINKS-1:0] i_link_credit_issued,
    input logic [NUM_LINKS-1:0] i_link_credit_held,
    input logic [NUM_LINKS-1:0] o_link_greeting_start,
    input logic [NUM_LINKS-1:0] o_link_rx_reset,
    input logic [NUM_LINKS-1:0] o_static_enable,
    input logic o_write_locked,
    input logic [15:0] o_node_identifier,
    input logic o_tile_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire [7:0] idx = i_avs_address[9:2];
    wire rd_ok = i_avs_read && !o_avs_waitrequest;
    wire wr_ok = i_avs_write && !o_avs_waitrequest && !o_write_locked;
    wire lk = wr_ok && i_avs_address[9:5] == 5'h10;
    ////////////////////////////////////////////////////////////////////////
    property p_lock_hold; o_write_locked |=> o_write_locked; endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock bit fell");
    property p_locked; $past(o_write_locked) |-> $stable(o_node_identifier)
        && $stable(o_static_enable); endproperty
    a_locked: assert property (p_locked) else $error("write landed while locked");
    property p_greet; o_link_greeting_start == ($past(lk && i_avs_writedata[24]
        && i_avs_byteenable[3]) ? 8'h01 << $past(i_avs_address[4:2]) : 8'h00); endproperty
    a_greet: assert property (p_greet) else $error("greeting pulse wrong");
    property p_rx; o_link_rx_reset == ($past(lk && i_avs_writedata[23]
        && i_avs_byteenable[2]) ? 8'h01 << $past(i_avs_address[4:2]) : 8'h00); endproperty
    a_rx: assert property (p_rx) else $error("receiver reset pulse wrong");
    property p_tile; o_tile_reset |-> $past(wr_ok && idx == 8'h06) ##1 !o_tile_reset;
    endproperty
    a_tile: assert property (p_tile) else $error("tile reset without cause");
    property p_node; rd_ok && idx == 8'h05 |-> o_avs_readdata == {16'h0000,
        $past(o_node_identifier)}; endproperty
    a_node: assert property (p_node) else $error("node id read wrong");
    property p_desc; rd_ok && idx == 8'h01 |-> o_avs_readdata == 32'h0008_0104; endproperty
    a_desc: assert property (p_desc) else $error("description read wrong");
    property p_pc; rd_ok && idx == 8'h40 |-> o_avs_readdata ==
        $past(i_core0_program_counter); endproperty
    a_pc: assert property (p_pc) else $error("program counter read wrong");
    property p_credit; rd_ok && i_avs_address[9:5] == 5'h10 |-> o_avs_readdata[26:25] ==
        {$past(i_link_credit_issued[i_avs_address[4:2]]),
        $past(i_link_credit_held[i_avs_address[4:2]])}; endproperty
    a_credit: assert property (p_credit) else $error("credit bits wrong");
endmodule // switch_link_config_regs_sva
bind switch_link_config_regs switch_link_config_regs_sva #(.NUM_LINKS(NUM_LINKS)) u_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_core0_program_counter(i_core0_program_counter),
    .i_link_credit_issued(i_link_credit_issued), .i_link_credit_held(i_link_credit_held),
    .o_link_greeting_start(o_link_greeting_start), .o_link_rx_reset(o_link_rx_reset),
    .o_static_enable(o_static_enable), .o_write_locked(o_write_locked),
    .o_node_identifier(o_node_identifier), .o_tile_reset(o_tile_reset));

/* testbench/switch_link_config_regs_test.sv */
// Purpose: Self-checking bench of the switch link register block
// Assumes: Avalon-MM master tasks and a remote link model
// Notes: Lock runs last because it cannot be undone
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module switch_link_config_regs_test;
    logic i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, slow = 0, ps_wr = 0, hdr, lck;
    logic [9:0] addr = '0;
    logic [31:0] wdata = '0, pc = '0, ps_wd = '0, q, rdata, ps_rd, clkm;
    logic [3:0] be = '0, processor_link = '0;
    logic [2:0] ps_idx = '0;
    logic [7:0] bad_ovf = '0, bad_tok = '0, ci, ch, ovf, tok, en, fw, gr, se, rxr;
    logic [87:0] sg, tg;
    logic [39:0] sc;
    logic [15:0] nid;
    logic wreq, trst;
    int error_cnt = 0, n_tests = 0;
    switch_link_config_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_processor_link_route_into_switch(processor_link),
        .i_core0_program_counter(pc), .i_ps_scratch_write(ps_wr), .i_ps_scratch_index(ps_idx),
        .i_ps_scratch_wdata(ps_wd), .o_ps_scratch_rdata(ps_rd), .i_link_rx_overflow(ovf),
        .i_link_illegal_token(tok), .i_link_credit_issued(ci), .i_link_credit_held(ch),
        .o_link_enable(en), .o_link_five_wire(fw), .o_link_greeting_start(gr),
        .o_link_rx_reset(rxr), .o_link_symbol_gap(sg), .o_link_token_gap(tg),
        .o_static_enable(se), .o_static_channel_end(sc), .o_one_byte_headers(hdr),
        .o_write_locked(lck), .o_node_identifier(nid), .o_clock_multiplier_settings(clkm),
        .o_tile_reset(trst));
    remote_link_end far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow), .i_enable(en),
        .i_greeting(gr), .i_bad_ovf(bad_ovf), .i_bad_tok(bad_tok), .o_credit_issued(ci),
        .o_credit_held(ch), .o_overflow(ovf), .o_illegal(tok));
    ////////////////////////////////////////////////////////////////////////
    // Request held until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge i_clk);
        rd <= !w; wr <= w; addr <= {i, 2'b00}; wdata <= d; be <= b;
        do begin @(posedge i_clk); end while (wreq !== 1'b0);
        q = rdata;
        rd <= 0; wr <= 0;
        @(negedge i_clk);
    endtask
    task automatic t_defaults();
        logic [7:0] z [6] = '{8'h04, 8'h05, 8'h06, 8'h80, 8'ha0, 8'h02};
        bus(0, 8'h01, 0, 0); `CHK("description", 32'h0008_0104, q)
        foreach (z[i]) begin bus(0, z[i], 0, 0); `CHK("reset value", 32'h0, q) end
        $display("test defaults done");
    endtask
    task automatic t_node();
        bus(1, 8'h05, 32'hffff_ffff, 4'hf);
        bus(0, 8'h05, 0, 0); `CHK("node id", 32'h0000_ffff, q)
        `CHK("node id port", 16'hffff, nid)
        bus(1, 8'h01, 32'hffff_ffff, 4'hf);
        bus(0, 8'h01, 0, 0); `CHK("description kept", 32'h0008_0104, q)
        $display("test node done");
    endtask
    task automatic t_link();
        slow <= 1;
        bus(1, 8'h82, 32'hc1ff_ffff, 4'hf);
        `CHK("greeting", 8'h04, gr)
        `CHK("rx reset", 8'h04, rxr)
        `CHK("enable", 8'h04, en)
        `CHK("five wire", 8'h04, fw)
        `CHK("symbol gap", 11'h7ff, sg[22+:11])
        `CHK("token gap", 11'h7ff, tg[22+:11])
        bus(0, 8'h82, 0, 0); `CHK("credit dropped", 32'hc43f_ffff, q)
        repeat (25) @(posedge i_clk);
        bus(0, 8'h82, 0, 0); `CHK("credit back", 32'hc63f_ffff, q)
        bus(1, 8'h82, 32'h8000_0000, 4'hb);
        bus(0, 8'h82, 0, 0); `CHK("lane merge", 32'h863f_0000, q)
        `CHK("two wire", 8'h00, fw)
        `CHK("symbol gap lanes", 11'h7e0, sg[22+:11])
        `CHK("token gap lanes", 11'h000, tg[22+:11])
        slow <= 0;
        bus(1, 8'h85, 32'h8100_0000, 4'h8);
        repeat (5) @(posedge i_clk);
        bus(0, 8'h85, 0, 0); `CHK("prompt reply", 32'h8600_0000, q)
        $display("test link done");
    endtask
    task automatic t_err();
        logic [31:0] e [2] = '{32'h863f_0000, 32'h8600_0000};
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            if (i == 0) bad_ovf <= 8'h04;
            else bad_tok <= 8'h20;
            @(posedge i_clk);
            bad_ovf <= 0; bad_tok <= 0;
            bus(0, i ? 8'h85 : 8'h82, 0, 0); `CHK("error set", e[i] | 32'h0800_0000, q)
            bus(0, i ? 8'h85 : 8'h82, 0, 0); `CHK("error cleared", e[i], q)
        end
        $display("test errors done");
    endtask
    task automatic t_static();
        for (int i = 0; i < 8; i++) begin
            bus(1, 8'ha0 + i[7:0], 32'hffff_ffe0 | i, 4'hf);
            bus(0, 8'ha0 + i[7:0], 0, 0); `CHK("static", 32'h8000_0000 | i, q)
            `CHK("channel end", i[4:0], sc[i*5+:5])
        end
        `CHK("static enable", 8'hff, se)
        $display("test static done");
    endtask
    task automatic t_scratch();
        bus(1, 8'h23, 32'h5a5a_a5a5, 4'hf);
        @(posedge i_clk);
        ps_idx <= 3'd3;
        repeat (2) @(posedge i_clk);
        `CHK("scratch to core", 32'h5a5a_a5a5, ps_rd)
        ps_wr <= 1; ps_idx <= 3'd6; ps_wd <= 32'h0f0f_1234;
        @(posedge i_clk);
        ps_wr <= 0;
        bus(0, 8'h26, 0, 0); `CHK("scratch to bus", 32'h0f0f_1234, q)
        $display("test scratch done");
    endtask
    task automatic t_status();
        @(posedge i_clk);
        pc <= 32'h1234_abcd; processor_link <= 4'b0101;
        bus(0, 8'h40, 0, 0); `CHK("program counter", 32'h1234_abcd, q)
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'h10 + i[7:0], 0, 0); `CHK("route", {31'h0, processor_link[i]}, q)
        end
        $display("test status done");
    endtask
    task automatic t_cfg();
        bus(1, 8'h06, 32'h00a1_b2c3, 4'hf);
        `CHK("tile reset", 1'b1, trst)
        bus(0, 8'h06, 0, 0); `CHK("clock mult", 32'h00a1_b2c3, q)
        bus(1, 8'h04, 32'hffff_ffff, 4'h3);
        bus(0, 8'h04, 0, 0); `CHK("switch cfg", 32'h0000_0101, q)
        `CHK("header mode", 1'b1, hdr)
        bus(1, 8'h06, 32'hffff_ffff, 4'hf);
        `CHK("clock mult kept", 32'h00a1_b2c3, clkm)
        `CHK("tile reset held", 1'b0, trst)
        bus(1, 8'h04, 32'h8000_0000, 4'h8);
        `CHK("locked", 1'b1, lck)
        bus(1, 8'h05, 32'h0, 4'hf);
        bus(0, 8'h05, 0, 0); `CHK("node locked", 32'h0000_ffff, q)
        bus(1, 8'h04, 32'h0, 4'hf);
        bus(0, 8'h04, 0, 0); `CHK("lock stays", 32'h8000_0101, q)
        $display("test config done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        #(5 * 5000);
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1;
        t_defaults();
        t_node();
        t_link();
        t_err();
        t_static();
        t_scratch();
        t_status();
        t_cfg();
        test_done();
    end
endmodule // switch_link_config_regs_test
